// *** inc/pll_cfg_pkg.sv ***
// constants and carrier types for the synthesizer configuration register bank
package pll_cfg_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int REF_LOSS_NS = 1000;
  localparam int REF_LOSS_CYCLES = (REF_LOSS_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                   (REF_LOSS_NS / CLK_PERIOD_NS);

  // ==========================================================================
  // register select codes
  localparam logic [3:0] SEL_FREQ_ZERO = 4'h0;
  localparam logic [3:0] SEL_PUMP_CTRL = 4'h4;
  localparam logic [3:0] SEL_FIXED_A = 4'h5;
  localparam logic [3:0] SEL_OUT_BLEED = 4'h6;
  localparam logic [3:0] SEL_LOCK_DET = 4'h7;
  localparam logic [3:0] SEL_FIXED_B = 4'h8;
  localparam logic [3:0] SEL_CAL_TIME = 4'h9;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ==========================================================================
  // charge_pump_divider_control fields
  localparam int PUMP_HIZ_BIT = 5;
  localparam int DIV_RESET_BIT = 4;
  localparam int DBUF_BIT = 14;

  // output_bleed_feedback_config fields
  localparam int GATED_BLEED_BIT = 30;
  localparam int NEG_BLEED_BIT = 29;
  localparam int FB_SRC_BIT = 24;
  localparam int OUT_DIV_LSB = 21;
  localparam int BLEED_LVL_LSB = 13;
  localparam int MUTE_LOCK_BIT = 11;
  localparam int SEC_EN_BIT = 9;
  localparam int SEC_PWR_LSB = 7;
  localparam int PRI_EN_BIT = 6;
  localparam int PRI_PWR_LSB = 4;

  // lock_detect_config fields
  localparam int LE_SYNC_BIT = 25;
  localparam int LOCK_CNT_LSB = 8;
  localparam int REF_LOSS_BIT = 7;
  localparam int WIN_SEL_LSB = 5;
  localparam int WIN_MODE_BIT = 4;

  // oscillator_calibration_timing fields
  localparam int BAND_DIV_LSB = 24;
  localparam int BAND_TMO_LSB = 14;
  localparam int LVL_WAIT_LSB = 9;

  // ==========================================================================
  // lock detector consecutive-cycle counts per lock_count_select code
  localparam logic [11:0] LOCK_COUNT_0 = 12'h010;
  localparam logic [11:0] LOCK_COUNT_1 = 12'h020;
  localparam logic [11:0] LOCK_COUNT_2 = 12'h040;
  localparam logic [11:0] LOCK_COUNT_3 = 12'h080;

  typedef enum logic {LOAD_IDLE, LOAD_WAIT_REF} load_state_e;

  typedef struct packed {
    logic pumpHighImpedance;
    logic dividerReset;
    logic bleedCurrentOn;
    logic negativeBleedEnable;
    logic [7:0] bleedCurrentLevel;
    logic feedbackSourceSelect;
    logic [2:0] outputDividerSelect;
    logic outputStagePowered;
    logic secondaryEnable;
    logic [1:0] secondaryPower;
    logic primaryEnable;
    logic [1:0] primaryPower;
    logic referenceLossMode;
    logic [1:0] lockWindowSelect;
    logic lockWindowMode;
    logic lockDetect;
    logic [7:0] bandDivisionValue;
    logic [9:0] bandSelectTimeout;
    logic [4:0] levelCalWait;
    logic [31:0] reservedWordA;
    logic [31:0] reservedWordB;
  } synth_ctrl_s;

endpackage

// *** logic/pin_sync.sv ***
// two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  always_comb begin
    next_stage1 = d;
    next_q = stage1;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= next_stage1;
      q <= next_q;
    end
  end
endmodule

// *** logic/pll_synth_config_regs.sv ***
// configuration register bank behind the three-wire programming link
`timescale 1ns/100ps
module pll_synth_config_regs (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic loadStrobe,
  input wire logic referenceIn,
  input wire logic phaseInWindow,
  output pll_cfg_pkg::synth_ctrl_s ctrl,
  output logic frequencyUpdate
);
  import pll_cfg_pkg::*;

  // ==========================================================================
  // pin synchronisation
  logic [4:0] pinSync;

  pin_sync #(.W(5)) u_pin_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .d({serialClock, serialData, loadStrobe, referenceIn, phaseInWindow}),
    .q(pinSync)
  );

  logic sclkS, dataS, leS, refS, winS;
  assign {sclkS, dataS, leS, refS, winS} = pinSync;

  // ==========================================================================
  // serial shift and load
  logic prevSclk, prevLe, prevRef;
  logic [31:0] shiftReg, heldWord;
  load_state_e loadState;
  logic next_prevSclk, next_prevLe, next_prevRef;
  logic [31:0] next_shiftReg, next_heldWord;
  load_state_e next_loadState;
  logic sclkRise, leRise, refRise, commitNow;
  logic [31:0] commitWord;
  logic [31:0] reg4, reg5, reg6, reg7, reg8, reg9;

  always_comb begin
    sclkRise = sclkS & ~prevSclk;
    leRise = leS & ~prevLe;
    refRise = refS & ~prevRef;
    next_prevSclk = sclkS;
    next_prevLe = leS;
    next_prevRef = refS;
    next_shiftReg = shiftReg;
    next_heldWord = heldWord;
    next_loadState = loadState;
    commitNow = 1'b0;
    commitWord = shiftReg;
    if (sclkRise) begin
      next_shiftReg = {shiftReg[30:0], dataS};
    end
    case (loadState)
      LOAD_IDLE: begin
        if (leRise) begin
          if (reg7[LE_SYNC_BIT]) begin
            next_heldWord = shiftReg;
            next_loadState = LOAD_WAIT_REF;
          end else begin
            commitNow = 1'b1;
          end
        end
      end
      LOAD_WAIT_REF: begin
        commitWord = heldWord;
        if (refRise) begin
          commitNow = 1'b1;
          next_loadState = LOAD_IDLE;
        end
      end
      default: begin
        next_loadState = LOAD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prevSclk <= 1'b0;
      prevLe <= 1'b0;
      prevRef <= 1'b0;
      shiftReg <= REG_RESET;
      heldWord <= REG_RESET;
      loadState <= LOAD_IDLE;
    end else begin
      prevSclk <= next_prevSclk;
      prevLe <= next_prevLe;
      prevRef <= next_prevRef;
      shiftReg <= next_shiftReg;
      heldWord <= next_heldWord;
      loadState <= next_loadState;
    end
  end

  // ==========================================================================
  // register file and divider shadow
  logic [31:0] next_reg4, next_reg5, next_reg6, next_reg7, next_reg8, next_reg9;
  logic [2:0] divActive, next_divActive;
  logic next_frequencyUpdate;
  logic [3:0] commitSel;

  always_comb begin
    commitSel = commitWord[3:0];
    next_reg4 = reg4;
    next_reg5 = reg5;
    next_reg6 = reg6;
    next_reg7 = reg7;
    next_reg8 = reg8;
    next_reg9 = reg9;
    next_divActive = divActive;
    next_frequencyUpdate = 1'b0;
    if (commitNow) begin
      case (commitSel)
        SEL_FREQ_ZERO: begin
          next_frequencyUpdate = 1'b1;
          next_divActive = reg6[OUT_DIV_LSB +: 3];
        end
        SEL_PUMP_CTRL: next_reg4 = commitWord;
        SEL_FIXED_A: next_reg5 = commitWord;
        SEL_OUT_BLEED: begin
          next_reg6 = commitWord;
          if (!reg4[DBUF_BIT]) begin
            next_divActive = commitWord[OUT_DIV_LSB +: 3];
          end
        end
        SEL_LOCK_DET: next_reg7 = commitWord;
        SEL_FIXED_B: next_reg8 = commitWord;
        SEL_CAL_TIME: next_reg9 = commitWord;
        default: begin
          next_divActive = divActive;
        end
      endcase
    end
  end

  // only the reset pin clears the bank, never a power-down bit
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg4 <= REG_RESET;
      reg5 <= REG_RESET;
      reg6 <= REG_RESET;
      reg7 <= REG_RESET;
      reg8 <= REG_RESET;
      reg9 <= REG_RESET;
      divActive <= 3'h0;
      frequencyUpdate <= 1'b0;
    end else begin
      reg4 <= next_reg4;
      reg5 <= next_reg5;
      reg6 <= next_reg6;
      reg7 <= next_reg7;
      reg8 <= next_reg8;
      reg9 <= next_reg9;
      divActive <= next_divActive;
      frequencyUpdate <= next_frequencyUpdate;
    end
  end

  // ==========================================================================
  // digital lock detector
  logic [11:0] lockCount, next_lockCount, lockThreshold;
  logic [7:0] quietCount, next_quietCount;
  logic locked, next_locked, refLost;

  always_comb begin
    case (reg7[LOCK_CNT_LSB +: 2])
      2'h0: lockThreshold = LOCK_COUNT_0;
      2'h1: lockThreshold = LOCK_COUNT_1;
      2'h2: lockThreshold = LOCK_COUNT_2;
      default: lockThreshold = LOCK_COUNT_3;
    endcase
    next_quietCount = quietCount;
    if (refRise) begin
      next_quietCount = 8'h00;
    end else if (quietCount < 8'(REF_LOSS_CYCLES)) begin
      next_quietCount = quietCount + 8'h01;
    end
    refLost = reg7[REF_LOSS_BIT] && (quietCount >= 8'(REF_LOSS_CYCLES));
    next_lockCount = lockCount;
    if (reg4[DIV_RESET_BIT] || refLost) begin
      next_lockCount = 12'h000;
    end else if (refRise) begin
      if (!winS) begin
        next_lockCount = 12'h000;
      end else if (lockCount < lockThreshold) begin
        next_lockCount = lockCount + 12'h001;
      end
    end
    next_locked = (next_lockCount >= lockThreshold);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lockCount <= 12'h000;
      quietCount <= 8'h00;
      locked <= 1'b0;
    end else begin
      lockCount <= next_lockCount;
      quietCount <= next_quietCount;
      locked <= next_locked;
    end
  end

  // ==========================================================================
  // control outputs
  synth_ctrl_s next_ctrl;

  always_comb begin
    next_ctrl.pumpHighImpedance = reg4[PUMP_HIZ_BIT];
    next_ctrl.dividerReset = reg4[DIV_RESET_BIT];
    next_ctrl.negativeBleedEnable = reg6[NEG_BLEED_BIT];
    next_ctrl.bleedCurrentOn = reg6[NEG_BLEED_BIT] &&
                               (!reg6[GATED_BLEED_BIT] || locked);
    next_ctrl.bleedCurrentLevel = reg6[BLEED_LVL_LSB +: 8];
    next_ctrl.feedbackSourceSelect = reg6[FB_SRC_BIT];
    next_ctrl.outputDividerSelect = divActive;
    next_ctrl.outputStagePowered = !reg6[MUTE_LOCK_BIT] || locked;
    next_ctrl.secondaryEnable = reg6[SEC_EN_BIT];
    next_ctrl.secondaryPower = reg6[SEC_PWR_LSB +: 2];
    next_ctrl.primaryEnable = reg6[PRI_EN_BIT];
    next_ctrl.primaryPower = reg6[PRI_PWR_LSB +: 2];
    next_ctrl.referenceLossMode = reg7[REF_LOSS_BIT];
    next_ctrl.lockWindowSelect = reg7[WIN_SEL_LSB +: 2];
    next_ctrl.lockWindowMode = reg7[WIN_MODE_BIT];
    next_ctrl.lockDetect = locked;
    next_ctrl.bandDivisionValue = reg9[BAND_DIV_LSB +: 8];
    next_ctrl.bandSelectTimeout = reg9[BAND_TMO_LSB +: 10];
    next_ctrl.levelCalWait = reg9[LVL_WAIT_LSB +: 5];
    next_ctrl.reservedWordA = reg5;
    next_ctrl.reservedWordB = reg8;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_wait_ref;
    loadState == LOAD_WAIT_REF && refRise;
  endsequence

  sequence s_wait_quiet;
    loadState == LOAD_WAIT_REF && !refRise;
  endsequence

  a_shift_bit_in: assert property (sclkRise |=> shiftReg[0] == $past(dataS))
    else $error("serial bit not shifted in");
  a_sync_commit: assert property (s_wait_ref |-> commitNow)
    else $error("held word not committed on reference edge");
  a_sync_hold: assert property (s_wait_quiet |-> !commitNow)
    else $error("word committed before reference edge");
  a_out_word_write: assert property (commitNow && commitSel == SEL_OUT_BLEED
                                     |=> reg6 == $past(commitWord))
    else $error("output word not stored");
  a_freq_zero_pulse: assert property (commitNow && commitSel == SEL_FREQ_ZERO
                                      |=> frequencyUpdate)
    else $error("register zero write gave no update");
  a_dbuf_hold: assert property (reg4[DBUF_BIT] && !(commitNow && commitSel == SEL_FREQ_ZERO)
                                |=> $stable(divActive))
    else $error("divider select changed outside register zero");
  a_pump_hiz: assert property (##1 ctrl.pumpHighImpedance == $past(reg4[PUMP_HIZ_BIT]))
    else $error("pump state does not follow control bit");
  a_mute_lock: assert property (ctrl.outputStagePowered
                                |-> !$past(reg6[MUTE_LOCK_BIT]) || $past(locked))
    else $error("output powered before lock");
  a_gated_bleed: assert property (ctrl.bleedCurrentOn
                                  |-> !$past(reg6[GATED_BLEED_BIT]) || $past(locked))
    else $error("bleed on before lock");
  a_lock_count: assert property (locked |-> lockCount >= lockThreshold)
    else $error("lock without enough cycles");
  a_ref_loss: assert property (refLost |=> !locked)
    else $error("lock kept after reference loss");
  a_div_reset: assert property (reg4[DIV_RESET_BIT] |=> lockCount == 12'h000)
    else $error("lock counter runs during divider reset");
endmodule

// *** verif/serial_host_model.sv ***
// host controller model driving the three-wire programming link
`timescale 1ns/100ps
module serial_host_model (
  input wire logic clk_sys,
  output logic serialClock,
  output logic serialData,
  output logic loadStrobe
);
  import pll_cfg_pkg::*;
  // =====
  // link idle state
  initial begin
    serialClock = 1'b0;
    serialData = 1'b0;
    loadStrobe = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // =====
  // one word, msb first, strobe after the last bit
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      gap(1);
      serialData = w[i];
      gap(3);
      serialClock = 1'b1;
      gap(4);
      serialClock = 1'b0;
    end
    gap(1);
    serialData = ~serialData;
    loadStrobe = 1'b1;
    gap(4);
    loadStrobe = 1'b0;
    gap(10);
  endtask
  // =====
  // register writes with required reserved values
  task automatic write_reg(input logic [3:0] sel, input logic [31:0] p);
    logic [31:0] w;
    w = p;
    if (sel == SEL_OUT_BLEED) begin
      w = (p & 32'h61ff_ebf0) | 32'h1400_0000;
    end
    if (sel == SEL_LOCK_DET) begin
      w = (p & 32'h0200_03f0) | 32'h1000_0000;
    end
    send_word({w[31:4], sel});
  endtask
  task automatic program_fixed();
    send_word(32'h0080_0025);
    send_word(32'h102d_0428);
  endtask
  // divider reset wrapped around the register-zero write
  task automatic change_freq(input logic [31:0] pump, input logic [31:0] f);
    write_reg(SEL_PUMP_CTRL, pump | 32'h10);
    write_reg(SEL_FREQ_ZERO, f);
    write_reg(SEL_PUMP_CTRL, pump & ~32'h10);
  endtask
endmodule

// *** verif/pll_synth_config_regs_bench.sv ***
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
module pll_synth_config_regs_bench;
  import pll_cfg_pkg::*;
  // =====
  // stimulus signals
  localparam logic [31:0] OUT_BASE = 32'h6114_ab50;
  localparam logic [31:0] LOCK_BASE = 32'h0000_00f0;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic referenceIn = 1'b0;
  logic phaseInWindow = 1'b0;
  logic refRun = 1'b0;
  logic [2:0] refCount = 3'h0;
  logic serialClock;
  logic serialData;
  logic loadStrobe;
  logic frequencyUpdate;
  synth_ctrl_s ctrl;
  int failures = 0;
  int tests_run = 0;
  int pulses = 0;
  always #50 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    refCount <= refCount + 3'h1;
    referenceIn <= refRun & refCount[2];
  end
  always @(posedge clk_sys) begin
    if (frequencyUpdate === 1'b1) begin
      pulses++;
    end
  end
  // =====
  // instances
  serial_host_model u_host (.clk_sys(clk_sys), .serialClock(serialClock),
    .serialData(serialData), .loadStrobe(loadStrobe));
  pll_synth_config_regs u_dut (.clk_sys(clk_sys), .reset(reset), .serialClock(serialClock),
    .serialData(serialData), .loadStrobe(loadStrobe), .referenceIn(referenceIn),
    .phaseInWindow(phaseInWindow), .ctrl(ctrl), .frequencyUpdate(frequencyUpdate));
  // =====
  // checking and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0d ns: %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // =====
  // scenarios
  task automatic t_reset();
    synth_ctrl_s e;
    e = '0;
    e.outputStagePowered = 1'b1;
    check(32'({ctrl !== e, frequencyUpdate}), 32'h0, "outputs after reset");
    check(32'(ctrl.outputStagePowered), 32'h1, "unmuted after reset");
  endtask
  task automatic t_pump();
    u_host.write_reg(SEL_PUMP_CTRL, 32'h30);
    check(32'({ctrl.pumpHighImpedance, ctrl.dividerReset}), 32'h3, "pump set");
    u_host.write_reg(SEL_PUMP_CTRL, 32'h0);
    check(32'({ctrl.pumpHighImpedance, ctrl.dividerReset}), 32'h0, "pump clear");
  endtask
  task automatic t_output();
    u_host.write_reg(SEL_OUT_BLEED, OUT_BASE | 32'h00a0_0000);
    check(32'({ctrl.negativeBleedEnable, ctrl.feedbackSourceSelect, ctrl.bleedCurrentLevel}),
      32'h3a5, "bleed and feedback");
    check(32'({ctrl.secondaryEnable, ctrl.secondaryPower, ctrl.primaryEnable,
      ctrl.primaryPower}), 32'h35, "output enables");
    check(32'(ctrl.outputDividerSelect), 32'h5, "divider at once");
    check(32'({ctrl.bleedCurrentOn, ctrl.outputStagePowered}), 32'h0, "unlocked");
  endtask
  task automatic t_lock();
    u_host.write_reg(SEL_LOCK_DET, LOCK_BASE);
    check(32'({ctrl.referenceLossMode, ctrl.lockWindowSelect, ctrl.lockWindowMode}),
      32'hf, "lock fields");
    phaseInWindow = 1'b1;
    refRun = 1'b1;
    wait_clk(100);
    check(32'(ctrl.lockDetect), 32'h0, "lock too early");
    wait_clk(100);
    check(32'({ctrl.lockDetect, ctrl.bleedCurrentOn, ctrl.outputStagePowered}),
      32'h7, "locked");
    phaseInWindow = 1'b0;
    wait_clk(20);
    check(32'(ctrl.lockDetect), 32'h0, "window miss");
    phaseInWindow = 1'b1;
    wait_clk(160);
    check(32'(ctrl.lockDetect), 32'h1, "relocked");
    refRun = 1'b0;
    wait_clk(30);
    check(32'({ctrl.lockDetect, ctrl.outputStagePowered}), 32'h0, "reference lost");
  endtask
  task automatic t_dbuf();
    int n;
    u_host.write_reg(SEL_PUMP_CTRL, 32'h4000);
    u_host.write_reg(SEL_OUT_BLEED, OUT_BASE | 32'h0040_0000);
    check(32'(ctrl.outputDividerSelect), 32'h5, "divider held");
    n = pulses;
    u_host.change_freq(32'h4000, 32'h0000_1230);
    check(32'(pulses - n), 32'h1, "one update pulse");
    check(32'(ctrl.outputDividerSelect), 32'h2, "divider applied");
  endtask
  task automatic t_misc();
    u_host.write_reg(SEL_CAL_TIME, 32'h3ca9_6600);
    u_host.program_fixed();
    u_host.send_word(32'hffff_fffa);
    u_host.send_word(32'h0000_000f);
    check(32'({ctrl.bandDivisionValue, ctrl.bandSelectTimeout, ctrl.levelCalWait}),
      32'h001e_54b3, "calibration");
    check(ctrl.reservedWordA, 32'h0080_0025, "fixed word a");
    check(ctrl.reservedWordB, 32'h102d_0428, "fixed word b");
  endtask
  task automatic t_lesync();
    u_host.write_reg(SEL_LOCK_DET, LOCK_BASE | 32'h0200_0000);
    u_host.write_reg(SEL_OUT_BLEED, OUT_BASE | 32'h0040_0030);
    check(32'(ctrl.primaryPower), 32'h1, "waits for reference");
    refRun = 1'b1;
    wait_clk(20);
    check(32'(ctrl.primaryPower), 32'h3, "loaded on reference");
  endtask
  // =====
  // main sequence and watchdog
  initial begin
    wait_clk(12);
    reset = 1'b0;
    wait_clk(4);
    t_reset();
    t_pump();
    t_output();
    t_lock();
    t_dbuf();
    t_misc();
    t_lesync();
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    give_verdict();
  end
endmodule
